/* ldml_host_model.sv */
// Host microcontroller model that drives the loader's pins.
// Assumes clk is the loader's clock; the bench calls its tasks.
`timescale 1ns/1ps
module ldml_host_model (
   input  wire logic clk,
   output logic [7:0] hostInputBits,
   output logic [2:0] digitLocationSelect,
   output logic       modeSelect,
   output logic       writeStrobeN,
   output logic       formatOrSleepPinHigh,
   output logic       formatOrSleepPinLow
);
   // Pins start idle, with the strobe high and the level pin high.
   initial begin
      hostInputBits = 8'h00;
      digitLocationSelect = 3'h0;
      modeSelect = 1'b0;
      writeStrobeN = 1'b1;
      formatOrSleepPinHigh = 1'b1;
      formatOrSleepPinLow = 1'b0;
   end
   // One strobe with set-up and hold; the shared bus then shows junk.
   task automatic strobe(input logic m, input logic [2:0] loc,
                         input logic [7:0] d);
      @(posedge clk);
      modeSelect <= m;
      digitLocationSelect <= loc;
      hostInputBits <= d;
      repeat (5) @(posedge clk);
      writeStrobeN <= 1'b0;
      repeat (6) @(posedge clk);
      writeStrobeN <= 1'b1;
      repeat (6) @(posedge clk);
      hostInputBits <= ~d;
      repeat (2) @(posedge clk);
   endtask
   // Sets the three-level pin: 0 low, 1 high, 2 floating.
   task automatic set_level(input int lvl);
      @(posedge clk);
      formatOrSleepPinHigh <= (lvl == 1);
      formatOrSleepPinLow <= (lvl == 0);
   endtask
endmodule

/* ldml_pair_buf.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes the filler and the drainer share clk and the synchronous rst.
`timescale 1ns/1ps
module ldml_pair_buf #(
   parameter int WIDTH = 11
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   logic [1:0]       count_r;
   logic [WIDTH-1:0] slot0_r;
   logic [WIDTH-1:0] slot1_r;
   wire              push;
   wire              pop;
   wire              headLoadIn;
   wire              headLoadTail;
   wire              tailLoad;

   // Handshakes and slot steering; the head slot is always the output.
   assign inReady      = count_r != ldml_pkg::BUF_FULL;
   assign outValid     = count_r != ldml_pkg::BUF_EMPTY;
   assign outData      = slot0_r;
   assign push         = inValid && inReady;
   assign pop          = outValid && outReady;
   assign headLoadIn   = push && ((count_r == ldml_pkg::BUF_EMPTY) ||
                         ((count_r == ldml_pkg::BUF_ONE) && pop));
   assign headLoadTail = pop && (count_r == ldml_pkg::BUF_FULL);
   assign tailLoad     = push && (count_r == ldml_pkg::BUF_ONE) && !pop;

   // Fill level follows pushes and pops.
   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= ldml_pkg::BUF_EMPTY;
      end else if (push && !pop) begin
         count_r <= count_r + ldml_pkg::BUF_ONE;
      end else if (pop && !push) begin
         count_r <= count_r - ldml_pkg::BUF_ONE;
      end
   end

   // Slot contents need no reset, they are qualified by the fill level.
   always_ff @(posedge clk) begin
      if (headLoadIn) begin
         slot0_r <= inData;
      end else if (headLoadTail) begin
         slot0_r <= slot1_r;
      end
      if (tailLoad) begin
         slot1_r <= inData;
      end
   end
endmodule

/* ldml_pkg.sv */
// Constants, field positions, bus offsets and state codes of the LED
// display memory loader.
// Assumes a 100 MHz clk and a synchronous, active-high reset.
// Function
// R01: In random access mode the three-level pin picks format or shutdown at any time, with or without a write strobe.
// R02: In random access mode a low write strobe stores the input byte at the location named by the three address bits.
// R03: A random access write changes only the addressed location and no other.
// R04: In sequential mode the one eight-bit input bus carries both control words and display data.
// R05: In sequential mode a strobe with mode select high is a control word and with mode select low is display data.
// R06: In sequential mode data writes fill consecutive locations while a pointer steps on by itself.
// R07: After eight data writes further strobes are ignored and memory is untouched until a new control word comes.
// R08: A host that wants discrete indicators first writes a control word with raw segment mode and data-follows set.
// R09: In raw segment mode each stored bit drives one output, giving eight segments by eight digits of indicators.
// R10: In random access mode a low pin means shutdown, a high pin means base-sixteen decode, a floating pin the other font.
// R11: Memory writes are still taken during shutdown; only the display outputs are switched off.
// R12: In raw segment mode a one lights its segment, except the decimal point, which lights on a zero.
// R13: In decoded formats only the low four bits and the top bit are kept; the bits between are ignored.
// R14: After reset the sequential pointer is exhausted, so data writes wait for a control word with data-follows set.
// R15: A control word with data-follows set rewinds the sequential pointer to the first location.
package ldml_pkg;
   localparam int          DIGITS       = 8;
   localparam int          BYTE_W       = 8;
   localparam int          LOC_W        = 3;
   localparam int          PTR_W        = 4;
   localparam logic [3:0]  PTR_FIRST    = 4'h0;
   localparam logic [3:0]  PTR_DONE     = 4'h8;
   localparam logic [3:0]  PTR_STEP     = 4'h1;
   // Control word fields.
   localparam int          CW_FOLLOWS   = 7;
   localparam int          CW_HEX       = 6;
   localparam int          CW_RAW       = 5;
   localparam int          CW_RUN       = 4;
   localparam int          DP_BIT       = 7;
   localparam logic [7:0]  DECODE_KEEP  = 8'h8f;
   localparam logic [7:0]  SEG_OFF      = 8'h00;
   // Positions of the pin inputs inside the synchroniser vector.
   localparam int          PIN_W        = 15;
   localparam int          PIN_WR       = 0;
   localparam int          PIN_HI       = 1;
   localparam int          PIN_LO       = 2;
   localparam int          PIN_MODE     = 3;
   localparam int          PIN_DA       = 4;
   localparam int          PIN_ID       = 7;
   localparam logic [14:0] PIN_IDLE     = 15'h0001;
   // Register offsets, byte addresses on a 6-bit address.
   localparam int          ADDR_W       = 6;
   localparam logic [5:0]  ADDR_CTRL    = 6'h00;
   localparam logic [5:0]  ADDR_STATUS  = 6'h04;
   localparam int          MEM_SEL_BIT  = 5;
   localparam logic        CTRL_RESET   = 1'b0;
   // Status word fields.
   localparam int          ST_SHUT      = 4;
   localparam int          ST_RAW       = 5;
   localparam int          ST_HEX       = 6;
   localparam int          ST_FULL      = 7;
   localparam int          ST_RANDOM    = 8;
   // Two-entry buffer fill levels.
   localparam logic [1:0]  BUF_EMPTY    = 2'h0;
   localparam logic [1:0]  BUF_ONE      = 2'h1;
   localparam logic [1:0]  BUF_FULL     = 2'h2;
   // Bus answer states.
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RESP = 2'b10
   } ldml_bus_t;
endpackage

/* led_display_memory_loader.sv */
// Host write port of an eight-digit display memory with its bus slave.
// Assumes pin inputs are asynchronous to clk and that the host sets up
// data, address and mode at least three cycles before the strobe falls.
`timescale 1ns/1ps
module led_display_memory_loader (
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM slave.
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Host pins.
   input  wire logic [7:0]  hostInputBits,
   input  wire logic [2:0]  digitLocationSelect,
   input  wire logic        modeSelect,
   input  wire logic        writeStrobeN,
   input  wire logic        formatOrSleepPinHigh,
   input  wire logic        formatOrSleepPinLow,
   output logic             hostBusy,
   // Display side.
   output logic [63:0]      displayOn,
   output logic             displayEnable,
   output logic             rawSegment,
   output logic             baseSixteenDecode
);
   localparam int ENTRY_W = ldml_pkg::LOC_W + ldml_pkg::BYTE_W;

   logic [ldml_pkg::PIN_W-1:0]  syncA_r;
   logic [ldml_pkg::PIN_W-1:0]  syncB_r;
   logic [ldml_pkg::PIN_W-1:0]  syncC_r;
   logic [ldml_pkg::PIN_W-1:0]  pinF_r;
   logic [ldml_pkg::PIN_W-1:0]  pinF_nxt;
   logic [7:0]                  memArr_r [ldml_pkg::DIGITS];
   logic [3:0]                  ptr_r;
   logic [3:0]                  ptr_nxt;
   logic                        cwRaw_r;
   logic                        cwHex_r;
   logic                        cwShut_r;
   logic                        ctrlRandom_r;
   logic [31:0]                 readdata_r;
   logic [63:0]                 displayOn_r;
   logic [63:0]                 seg_nxt;
   logic                        displayEnable_r;
   logic                        rawSegment_r;
   logic                        hexDecode_r;
   ldml_pkg::ldml_bus_t         busState_r;

   wire [ldml_pkg::PIN_W-1:0]   pinRaw;
   wire [ldml_pkg::PIN_W-1:0]   pinStable;
   wire                         wrFall;
   wire [7:0]                   dataF;
   wire [2:0]                   locF;
   wire                         modeF;
   wire                         randomMode;
   wire                         randEv;
   wire                         seqEv;
   wire                         seqCtrlEv;
   wire                         seqDataEv;
   wire                         ptrLive;
   wire                         pinShut;
   wire                         pinHex;
   wire                         shutdownNow;
   wire                         hexNow;
   wire                         rawNow;
   wire                         pushValid;
   wire [2:0]                   pushAddr;
   wire [7:0]                   pushData;
   wire                         bufInReady;
   wire                         bufOutValid;
   wire [ENTRY_W-1:0]           bufOutData;
   wire [2:0]                   drainAddr;
   wire [7:0]                   drainData;
   wire                         drainFire;
   wire                         busReq;
   wire                         busIdle;
   wire                         addrIsMem;
   wire [2:0]                   memIdx;
   wire                         memReadStall;
   wire                         ctrlWrite;
   wire [31:0]                  statusWord;
   wire [31:0]                  readSel;

   // Every pin passes three flip-flops; the filtered copy moves only
   // when the second and third stage agree.
   assign pinRaw = {hostInputBits, digitLocationSelect, modeSelect,
                    formatOrSleepPinLow, formatOrSleepPinHigh, writeStrobeN};
   assign pinStable = ~(syncB_r ^ syncC_r);

   genvar gi;
   generate
      for (gi = 0; gi < ldml_pkg::PIN_W; gi++) begin : g_filter
         assign pinF_nxt[gi] = pinStable[gi] ? syncB_r[gi] : pinF_r[gi];
      end
   endgenerate

   // Synchroniser chain and filtered pin levels.
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA_r <= ldml_pkg::PIN_IDLE;
         syncB_r <= ldml_pkg::PIN_IDLE;
         syncC_r <= ldml_pkg::PIN_IDLE;
         pinF_r  <= ldml_pkg::PIN_IDLE;
      end else begin
         syncA_r <= pinRaw;
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
         pinF_r  <= pinF_nxt;
      end
   end

   // A write is taken when the filtered strobe falls; the other pins
   // use their settled filtered values at that moment.
   assign wrFall = pinF_r[ldml_pkg::PIN_WR] && !pinF_nxt[ldml_pkg::PIN_WR];
   assign dataF  = pinF_r[ldml_pkg::PIN_ID +: ldml_pkg::BYTE_W]; // R04
   assign locF   = pinF_r[ldml_pkg::PIN_DA +: ldml_pkg::LOC_W];
   assign modeF  = pinF_r[ldml_pkg::PIN_MODE];

   // Split strobes by variant and, in sequential mode, by mode select.
   assign randomMode = ctrlRandom_r;
   assign randEv     = wrFall && randomMode;
   assign seqEv      = wrFall && !randomMode;
   assign seqCtrlEv  = seqEv && modeF; // R05
   assign seqDataEv  = seqEv && !modeF; // R05
   assign ptrLive    = ptr_r != ldml_pkg::PTR_DONE;

   // The three-level pin is read continuously, no strobe involved.
   assign pinShut     = pinF_r[ldml_pkg::PIN_LO]; // R01 R10
   assign pinHex      = pinF_r[ldml_pkg::PIN_HI] && !pinShut; // R10
   assign shutdownNow = randomMode ? pinShut : cwShut_r;
   assign hexNow      = randomMode ? pinHex : cwHex_r;
   assign rawNow      = !randomMode && cwRaw_r;

   // Entries for the buffer: random writes go to the named location,
   // sequential data to the pointer, and an exhausted pointer pushes none.
   assign pushValid = randEv || (seqDataEv && ptrLive); // R02 R07 R11
   assign pushAddr  = randEv ? locF : ptr_r[ldml_pkg::LOC_W-1:0]; // R02 R06
   assign pushData  = rawNow ? dataF : (dataF & ldml_pkg::DECODE_KEEP); // R13
   assign hostBusy  = !bufInReady;

   // Pointer: a control word rewinds or exhausts it, data steps it.
   always_comb begin
      ptr_nxt = ptr_r;
      if (seqCtrlEv) begin
         if (dataF[ldml_pkg::CW_FOLLOWS]) begin
            ptr_nxt = ldml_pkg::PTR_FIRST; // R15
         end else begin
            ptr_nxt = ldml_pkg::PTR_DONE;
         end
      end else if (seqDataEv && ptrLive && bufInReady) begin
         ptr_nxt = ptr_r + ldml_pkg::PTR_STEP; // R06
      end
   end

   // Pointer and control word fields.
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_r    <= ldml_pkg::PTR_DONE; // R14
         cwRaw_r  <= 1'b0;
         cwHex_r  <= 1'b1;
         cwShut_r <= 1'b0;
      end else begin
         ptr_r <= ptr_nxt;
         if (seqCtrlEv) begin
            cwRaw_r  <= dataF[ldml_pkg::CW_RAW];
            cwHex_r  <= dataF[ldml_pkg::CW_HEX];
            cwShut_r <= !dataF[ldml_pkg::CW_RUN];
         end
      end
   end

   // Two-entry buffer between the pin side and the memory write port.
   ldml_pair_buf #(
      .WIDTH (ENTRY_W)
   ) u_buf (
      .clk      (clk),
      .rst      (rst),
      .inValid  (pushValid),
      .inReady  (bufInReady),
      .inData   ({pushAddr, pushData}),
      .outValid (bufOutValid),
      .outReady (!memReadStall),
      .outData  (bufOutData)
   );

   assign drainAddr = bufOutData[ENTRY_W-1 -: ldml_pkg::LOC_W];
   assign drainData = bufOutData[ldml_pkg::BYTE_W-1:0];
   assign drainFire = bufOutValid && !memReadStall;

   // Memory writes one location per drained entry, shutdown or not.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < ldml_pkg::DIGITS; i++) begin
            memArr_r[i] <= ldml_pkg::SEG_OFF;
         end
      end else if (drainFire) begin
         memArr_r[drainAddr] <= drainData; // R03 R11
      end
   end

   // Display words; raw mode inverts the decimal point so a stored zero lights it.
   generate
      for (gi = 0; gi < ldml_pkg::DIGITS; gi++) begin : g_digit
         wire [7:0] m = memArr_r[gi];
         wire [7:0] rawSeg = {~m[ldml_pkg::DP_BIT], m[6:0]}; // R09 R12
         wire [7:0] decSeg = m & ldml_pkg::DECODE_KEEP; // R13
         assign seg_nxt[gi*8 +: 8] = shutdownNow ? ldml_pkg::SEG_OFF :
                                     (rawNow ? rawSeg : decSeg); // R10
      end
   endgenerate

   // Registered display side outputs.
   always_ff @(posedge clk) begin
      if (rst) begin
         displayOn_r     <= '0;
         displayEnable_r <= 1'b0;
         rawSegment_r    <= 1'b0;
         hexDecode_r     <= 1'b0;
      end else begin
         displayOn_r     <= seg_nxt;
         displayEnable_r <= !shutdownNow; // R10
         rawSegment_r    <= rawNow;
         hexDecode_r     <= hexNow;
      end
   end

   assign displayOn         = displayOn_r;
   assign displayEnable     = displayEnable_r;
   assign rawSegment        = rawSegment_r;
   assign baseSixteenDecode = hexDecode_r;

   // Bus decode; every access waits one cycle, memory reads hold the
   // drain for that cycle so the word loaded is the word returned.
   assign busReq       = read || write;
   assign busIdle      = busState_r == ldml_pkg::BUS_IDLE;
   assign waitrequest  = busReq && busIdle;
   assign addrIsMem    = address[ldml_pkg::MEM_SEL_BIT];
   assign memIdx       = address[4:2];
   assign memReadStall = busIdle && read && addrIsMem;
   assign ctrlWrite    = !busIdle && write &&
                         (address[5:2] == ldml_pkg::ADDR_CTRL[5:2]);
   assign statusWord   = {23'h000000, ctrlRandom_r, !bufInReady, hexNow,
                          rawNow, shutdownNow, ptr_r};
   assign readSel = addrIsMem ? {24'h000000, memArr_r[memIdx]} :
                    (address[5:2] == ldml_pkg::ADDR_CTRL[5:2]) ?
                    {31'h00000000, ctrlRandom_r} :
                    (address[5:2] == ldml_pkg::ADDR_STATUS[5:2]) ?
                    statusWord : 32'h00000000;
   assign readdata = readdata_r;

   // Bus state, read capture and the control register.
   always_ff @(posedge clk) begin
      if (rst) begin
         busState_r   <= ldml_pkg::BUS_IDLE;
         readdata_r   <= 32'h00000000;
         ctrlRandom_r <= ldml_pkg::CTRL_RESET;
      end else begin
         unique case (busState_r)
            ldml_pkg::BUS_IDLE: begin
               if (busReq) begin
                  busState_r <= ldml_pkg::BUS_RESP;
               end
               if (read) begin
                  readdata_r <= readSel;
               end
            end
            ldml_pkg::BUS_RESP: begin
               busState_r <= ldml_pkg::BUS_IDLE;
            end
            default: begin
               busState_r <= ldml_pkg::BUS_IDLE;
            end
         endcase
         if (ctrlWrite) begin
            ctrlRandom_r <= writedata[0];
         end
      end
   end

   // Checks on the behaviour above.
   sequence s_rewind;
      seqCtrlEv && dataF[ldml_pkg::CW_FOLLOWS];
   endsequence

   sequence s_step;
      seqDataEv && ptrLive && bufInReady;
   endsequence

   a_reset_exhaust: assert property (@(posedge clk) // R14
      rst |=> (ptr_r == ldml_pkg::PTR_DONE))
      else $error("Pointer not exhausted after reset.");

   a_ctrl_rewind: assert property (@(posedge clk) disable iff (rst) // R15
      s_rewind |=> (ptr_r == ldml_pkg::PTR_FIRST))
      else $error("Control word did not rewind the pointer.");

   a_ptr_advance: assert property (@(posedge clk) disable iff (rst) // R06
      s_step |-> (pushAddr == ptr_r[2:0]) ##1
      (ptr_r == $past(ptr_r) + ldml_pkg::PTR_STEP))
      else $error("Pointer did not step after a data write.");

   a_exhaust_ignore: assert property (@(posedge clk) disable iff (rst) // R07
      (seqEv && !ptrLive) |-> !pushValid ##1 !ptrLive || $past(modeF))
      else $error("Write taken with an exhausted pointer.");

   a_mode_split: assert property (@(posedge clk) disable iff (rst) // R05
      seqCtrlEv |-> !pushValid)
      else $error("Control word pushed as display data.");

   a_rand_addr: assert property (@(posedge clk) disable iff (rst) // R02
      randEv |-> pushValid && (pushAddr == locF))
      else $error("Random write lost or at wrong location.");

   a_shut_writes: assert property (@(posedge clk) disable iff (rst) // R11
      (randEv && shutdownNow && bufInReady && !bufOutValid) ##1
      !memReadStall |-> drainFire ##1
      (memArr_r[$past(locF, 2)] == $past(pushData, 2)))
      else $error("Write refused during shutdown.");

   a_decode_mask: assert property (@(posedge clk) disable iff (rst) // R13
      (pushValid && !rawNow) |-> (pushData[6:4] == 3'h0) &&
      (pushData[3:0] == dataF[3:0]) && (pushData[7] == dataF[7]))
      else $error("Decoded entry kept ignored bits.");

   a_pin_shutdown: assert property (@(posedge clk) disable iff (rst) // R01
      (randomMode && pinShut) [*2] |-> !displayEnable_r &&
      (displayOn_r == 64'h0000000000000000))
      else $error("Low format pin did not shut the display.");

   a_pin_hex: assert property (@(posedge clk) disable iff (rst) // R10
      (randomMode && pinF_r[ldml_pkg::PIN_HI] && !pinShut) |=>
      hexDecode_r && displayEnable_r)
      else $error("High format pin did not select hex decode.");

   a_raw_segment: assert property (@(posedge clk) disable iff (rst) // R09
      (rawNow && !shutdownNow) |=> (displayOn_r[7:0] ==
      {~$past(memArr_r[0][7]), $past(memArr_r[0][6:0])})) // R12
      else $error("Raw segment output does not follow memory.");

   a_bus_answer: assert property (@(posedge clk) disable iff (rst)
      (busReq && waitrequest) |=> !waitrequest)
      else $error("Bus answer later than one cycle.");

   generate
      for (gi = 0; gi < ldml_pkg::DIGITS; gi++) begin : g_keep
         a_other_kept: assert property (@(posedge clk) disable iff (rst)
            (drainFire && (drainAddr != gi)) |=> // R03
            (memArr_r[gi] == $past(memArr_r[gi])))
            else $error("Write disturbed another location.");
      end
   endgenerate
endmodule

/* led_display_memory_loader_tb_top.sv */
// Self-checking bench for the display memory loader.
// Assumes the host model drives the pins and the bench the bus.
`timescale 1ns/1ps
module led_display_memory_loader_tb_top;
   logic        clk;
   logic        rst;
   logic [5:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  hostInputBits;
   logic [2:0]  digitLocationSelect;
   logic        modeSelect;
   logic        writeStrobeN;
   logic        pinHigh;
   logic        pinLow;
   logic        hostBusy;
   logic [63:0] displayOn;
   logic        displayEnable;
   logic        rawSegment;
   logic        baseSixteenDecode;
   logic [7:0]  expMem [8];
   logic [31:0] d;
   int          nMismatch;
   int          nChecks;
   int          cycles = 0;

   // Free-running clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   led_display_memory_loader u_dut (
      .clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .hostInputBits(hostInputBits),
      .digitLocationSelect(digitLocationSelect),
      .modeSelect(modeSelect), .writeStrobeN(writeStrobeN),
      .formatOrSleepPinHigh(pinHigh), .formatOrSleepPinLow(pinLow),
      .hostBusy(hostBusy), .displayOn(displayOn),
      .displayEnable(displayEnable), .rawSegment(rawSegment),
      .baseSixteenDecode(baseSixteenDecode));

   ldml_host_model u_host (
      .clk(clk), .hostInputBits(hostInputBits),
      .digitLocationSelect(digitLocationSelect),
      .modeSelect(modeSelect), .writeStrobeN(writeStrobeN),
      .formatOrSleepPinHigh(pinHigh), .formatOrSleepPinLow(pinLow));

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", nChecks, nMismatch);
      if (nMismatch == 0 && nChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low; only the
   // bench timeout ends a wait that never completes.
   task automatic bus_op(input logic wr, input logic [5:0] a,
                         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      address <= a;
      writedata <= wd;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // Reads every location and compares memory and display bytes.
   task automatic check_all(input logic raw, input logic on);
      logic [7:0] dv;
      for (int i = 0; i < 8; i++) begin
         bus_op(1'b0, 6'h20 + 6'(4 * i), 32'h0, d);
         chk(d, {24'h0, expMem[i]});
         dv = raw ? {~expMem[i][7], expMem[i][6:0]} : expMem[i] & 8'h8f;
         chk({24'h0, displayOn[8*i +: 8]}, {24'h0, on ? dv : 8'h00});
      end
   endtask

   // Cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles > 6000) begin
         nMismatch++;
         end_of_test();
      end
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      address = 6'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      nMismatch = 0;
      nChecks = 0;
      for (int i = 0; i < 8; i++) expMem[i] = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus_op(1'b0, ldml_pkg::ADDR_STATUS, 32'h0, d);
      chk(d, 32'h48);
      chk({31'h0, hostBusy}, 32'h0);
      bus_op(1'b0, 6'h10, 32'h0, d);
      chk(d, 32'h0);
      u_host.strobe(1'b0, 3'h0, 8'h11);
      check_all(1'b0, 1'b1);
      $display("test reset done");
      u_host.strobe(1'b1, 3'h0, 8'hd0);
      for (int i = 0; i < 9; i++) u_host.strobe(1'b0, 3'h0, 8'hf0 + 8'(i));
      for (int i = 0; i < 8; i++) expMem[i] = 8'h80 + 8'(i);
      check_all(1'b0, 1'b1);
      $display("test sequential done");
      u_host.strobe(1'b1, 3'h0, 8'hb0);
      for (int i = 0; i < 8; i++) begin
         expMem[i] = 8'(i * 33);
         u_host.strobe(1'b0, 3'h0, expMem[i]);
      end
      check_all(1'b1, 1'b1);
      chk({31'h0, rawSegment}, 32'h1);
      chk({31'h0, baseSixteenDecode}, 32'h0);
      u_host.strobe(1'b1, 3'h0, 8'h30);
      u_host.strobe(1'b0, 3'h0, 8'hff);
      check_all(1'b1, 1'b1);
      $display("test raw done");
      u_host.strobe(1'b1, 3'h0, 8'hc0);
      u_host.strobe(1'b0, 3'h0, 8'h8a);
      expMem[0] = 8'h8a;
      check_all(1'b0, 1'b0);
      chk({31'h0, displayEnable}, 32'h0);
      $display("test shutdown done");
      bus_op(1'b1, ldml_pkg::ADDR_CTRL, 32'h1, d);
      bus_op(1'b0, ldml_pkg::ADDR_CTRL, 32'h0, d);
      chk(d, 32'h1);
      u_host.set_level(1);
      u_host.strobe(1'b0, 3'h7, 8'h85);
      expMem[7] = 8'h85;
      check_all(1'b0, 1'b1);
      chk({30'h0, displayEnable, baseSixteenDecode}, 32'h3);
      u_host.set_level(2);
      repeat (8) @(posedge clk);
      chk({30'h0, displayEnable, baseSixteenDecode}, 32'h2);
      u_host.set_level(0);
      u_host.strobe(1'b0, 3'h3, 8'h07);
      expMem[3] = 8'h07;
      check_all(1'b0, 1'b0);
      chk({31'h0, displayEnable}, 32'h0);
      $display("test random done");
      end_of_test();
   end
endmodule
